//--- hdl/adc_front_pkg.sv
// Contract
// - capture serial input on sclk rising edge
// - shift result out on sclk rising edges
// - outputs high impedance while select high
// - no bits shifted unless select low
// - strobe high one period before msb
// - shutdown input forces shutdown state always
// - single-ended: selected channel positive, negative common
// - differential: only pairs 0/1,2/3,4/5,6/7
// - three-clock acquisition ends after last bit
// - conversion spans fifteen serial clock periods
// - successive approximation to twelve bits
// - first one after select is control msb
// - tracking starts after fifth control bit
// - three zeros, twelve bits, one trailing zero
package adc_front_pkg;
    localparam int unsigned CTRL_BITS   = 8;
    localparam int unsigned RES_BITS    = 12;
    localparam int unsigned LEAD_ZEROS  = 3;
    localparam int unsigned CONV_CLKS   = 15;
    localparam int unsigned TRACK_AFTER = 5;
    localparam logic [3:0]  CNT_ZERO    = 4'h0;
    localparam logic [7:0]  CTRL_RESET  = 8'h00;
    localparam logic [11:0] RES_RESET   = 12'h000;
    localparam logic [2:0]  CH_COM      = 3'h0;
    typedef enum {ST_IDLE, ST_CTRL, ST_CONV} fe_state_t;
endpackage

//--- hdl/sar_adc_serial_front_end.sv
module sar_adc_serial_front_end
    import adc_front_pkg::*;
(
    // system
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    // serial link, sampled as synchronous inputs
    input  wire logic        cs_n,
    input  wire logic        sclk,
    input  wire logic        din,
    output logic             dout_o,
    output logic             dout_oe_n,
    output logic             strobe_o,
    output logic             strobe_oe_n,
    // power
    input  wire logic        shutdown_n,
    output logic             powered_down,
    // analog front end control
    input  wire logic        comp_in,
    output logic [2:0]       pos_sel,
    output logic [2:0]       neg_sel,
    output logic             neg_is_com,
    output logic             tracking,
    output logic             hold_capacitor,
    output logic [11:0]      dac_code
);
    ////////////////////////////////////////////////////////////////
    fe_state_t   state_reg;
    fe_state_t   state_next;
    logic        sclk_reg;
    logic        sclk_next;
    logic [7:0]  ctrl_reg;
    logic [7:0]  ctrl_next;
    logic [3:0]  cnt_reg;
    logic [3:0]  cnt_next;
    logic [11:0] sar_reg;
    logic [11:0] sar_next;
    logic [3:0]  bit_reg;
    logic [3:0]  bit_next;
    logic [11:0] dac_next;
    logic        dout_next;
    logic        strobe_next;
    logic        oe_n_next;
    logic        trk_next;
    logic        hold_next;
    logic        pd_next;
    logic [2:0]  pos_next;
    logic [2:0]  neg_next;
    logic        negc_next;
    // decoded events
    logic        rise;
    logic        fall;
    logic        start_seen;
    logic        ctrl_rise;
    logic        ctrl_last;
    logic        track_open;
    logic        sample_close;
    logic        conv_rise;
    logic        decide;
    logic        conv_end;

    ////////////////////////////////////////////////////////////////
    // sclk edges seen at core_clk rate; needs at least one core cycle per half period
    assign rise         = sclk && !sclk_reg;
    assign fall         = !sclk && sclk_reg;
    // leading zeros fall through: only a one opens a frame
    assign start_seen   = !cs_n && state_reg == ST_IDLE && rise && din && shutdown_n;
    assign ctrl_rise    = !cs_n && state_reg == ST_CTRL && rise;
    assign ctrl_last    = ctrl_rise && cnt_reg == 4'(CTRL_BITS - 1);
    assign track_open   = !cs_n && state_reg == ST_CTRL && fall && cnt_reg == 4'(TRACK_AFTER);
    assign sample_close = !cs_n && state_reg == ST_CTRL && fall && cnt_reg == 4'(CTRL_BITS);
    assign conv_rise    = !cs_n && state_reg == ST_CONV && rise;
    assign decide       = conv_rise && cnt_reg >= 4'(LEAD_ZEROS - 1) &&
                          cnt_reg < 4'(LEAD_ZEROS - 1 + RES_BITS);
    assign conv_end     = conv_rise && cnt_reg == 4'(CONV_CLKS - 1);

    ////////////////////////////////////////////////////////////////
    always_comb begin
        sclk_next = sclk;
    end

    // parks at the idle level of sclk, so reset makes no false edge
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            sclk_reg <= 1'b0;
        end else begin
            sclk_reg <= sclk_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        ctrl_next  = ctrl_reg;
        if (cs_n) begin
            // abandon any frame in progress
            state_next = ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (start_seen) begin
                        state_next = ST_CTRL;
                        ctrl_next  = {CTRL_RESET[7:1], 1'b1};
                        cnt_next   = 4'h1;
                    end
                end
                ST_CTRL: begin
                    if (rise) begin
                        ctrl_next = {ctrl_reg[6:0], din};
                        cnt_next  = cnt_reg + 4'h1;
                    end
                    if (sample_close) begin
                        state_next = ST_CONV;
                        cnt_next   = CNT_ZERO;
                    end
                end
                ST_CONV: begin
                    if (rise) begin
                        cnt_next = cnt_reg + 4'h1;
                    end
                    if (conv_end) begin
                        state_next = ST_IDLE;
                    end
                end
                default: state_next = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= CNT_ZERO;
            ctrl_reg  <= CTRL_RESET;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            ctrl_reg  <= ctrl_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    always_comb begin
        pos_next  = pos_sel;
        neg_next  = neg_sel;
        negc_next = neg_is_com;
        if (ctrl_last) begin
            // last bit still on din: byte bit n sits at ctrl_reg[n-1]
            if (ctrl_reg[1]) begin
                pos_next  = {ctrl_reg[4], ctrl_reg[3], ctrl_reg[5]};
                neg_next  = CH_COM;
                negc_next = 1'b1;
            end else begin
                // pairs only: even channel positive, odd negative
                pos_next  = {ctrl_reg[4], ctrl_reg[3], 1'b0};
                neg_next  = {ctrl_reg[4], ctrl_reg[3], 1'b1};
                negc_next = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            pos_sel    <= CH_COM;
            neg_sel    <= CH_COM;
            neg_is_com <= 1'b1;
        end else begin
            pos_sel    <= pos_next;
            neg_sel    <= neg_next;
            neg_is_com <= negc_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    always_comb begin
        trk_next  = tracking;
        hold_next = hold_capacitor;
        if (cs_n) begin
            trk_next  = 1'b0;
            hold_next = 1'b0;
        end else begin
            if (track_open) begin
                trk_next = 1'b1;
            end
            if (sample_close) begin
                // acquisition closes, sample held
                trk_next  = 1'b0;
                hold_next = 1'b1;
            end
            if (conv_end) begin
                hold_next = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            tracking       <= 1'b0;
            hold_capacitor <= 1'b0;
        end else begin
            tracking       <= trk_next;
            hold_capacitor <= hold_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    always_comb begin
        sar_next = sar_reg;
        bit_next = bit_reg;
        if (sample_close) begin
            sar_next = RES_RESET;
            bit_next = 4'(RES_BITS - 1);
        end
        if (decide) begin
            // decide current bit from comparator
            sar_next[bit_reg] = comp_in;
            bit_next          = bit_reg - 4'h1;
        end
        // trial bit falls off the top once the last bit is decided
        dac_next = sar_next | ((state_next == ST_CONV) ? (12'h001 << bit_next) : RES_RESET);
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            sar_reg  <= RES_RESET;
            bit_reg  <= CNT_ZERO;
            dac_code <= RES_RESET;
        end else begin
            sar_reg  <= sar_next;
            bit_reg  <= bit_next;
            dac_code <= dac_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    always_comb begin
        dout_next   = dout_o;
        strobe_next = strobe_o;
        oe_n_next   = cs_n;
        if (cs_n) begin
            dout_next   = 1'b0;
            strobe_next = 1'b0;
        end else if (conv_rise) begin
            strobe_next = (cnt_reg == 4'(LEAD_ZEROS - 2));
            // zeros around the result are driven low whenever decide is false
            dout_next   = decide ? comp_in : 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            dout_o      <= 1'b0;
            dout_oe_n   <= 1'b1;
            strobe_o    <= 1'b0;
            strobe_oe_n <= 1'b1;
        end else begin
            dout_o      <= dout_next;
            dout_oe_n   <= oe_n_next;
            strobe_o    <= strobe_next;
            strobe_oe_n <= oe_n_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    always_comb begin
        pd_next = !shutdown_n;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            powered_down <= 1'b0;
        end else begin
            powered_down <= pd_next;
        end
    end
endmodule

//--- sim/adc_front_checker.sv
module adc_front_checker (
    // serial side
    input wire logic       core_clk,
    input wire logic       rst_b,
    input wire logic       cs_n,
    input wire logic       sclk,
    input wire logic       shutdown_n,
    input wire logic       dout_o,
    input wire logic       dout_oe_n,
    input wire logic       strobe_o,
    input wire logic       strobe_oe_n,
    input wire logic       powered_down,
    // analog control
    input wire logic [2:0] pos_sel,
    input wire logic [2:0] neg_sel,
    input wire logic       neg_is_com,
    input wire logic       tracking,
    input wire logic       hold_capacitor
);
    timeunit 1ns;
    timeprecision 1ns;
    logic sclk_reg;
    logic rise_now;
    always_ff @(posedge core_clk) sclk_reg <= sclk;
    // one or two cycles of output latency both accepted
    assign rise_now = sclk && !sclk_reg;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    out_float_a: assert property (cs_n |=> dout_oe_n && strobe_oe_n)
        else $error("outputs driven while deselected");
    idle_quiet_a: assert property (cs_n [*3] |-> !tracking && !hold_capacitor)
        else $error("sampling active while deselected");
    pwr_follow_a: assert property (1'b1 |=> powered_down == !$past(shutdown_n))
        else $error("shutdown state does not follow input");
    dout_edge_a: assert property (!cs_n && !dout_oe_n && $changed(dout_o)
        |-> $past(rise_now) || $past(rise_now, 2)) else $error("data moved off clock rise");
    strb_edge_a: assert property (!cs_n && !strobe_oe_n && $changed(strobe_o)
        |-> $past(rise_now) || $past(rise_now, 2)) else $error("strobe moved off clock rise");
    strb_hold_a: assert property ($rose(strobe_o) |-> hold_capacitor && !tracking)
        else $error("strobe outside conversion");
    track_excl_a: assert property (!(tracking && hold_capacitor))
        else $error("tracking while holding");
    xfer_abandon_a: assert property ($rose(cs_n) |-> ##[1:2] !hold_capacitor && !tracking)
        else $error("transfer not abandoned");
    diff_pair_a: assert property (hold_capacitor && !neg_is_com
        |-> !pos_sel[0] && neg_sel == (pos_sel | 3'h1)) else $error("illegal pair");
endmodule
bind sar_adc_serial_front_end adc_front_checker u_chk (.core_clk, .rst_b, .cs_n, .sclk,
    .shutdown_n, .dout_o, .dout_oe_n, .strobe_o, .strobe_oe_n, .powered_down, .pos_sel,
    .neg_sel, .neg_is_com, .tracking, .hold_capacitor);

//--- sim/host_master.sv
module host_master (
    // sensed pins
    input  wire logic core_clk,
    input  wire logic dout_o,
    input  wire logic dout_oe_n,
    input  wire logic strobe_o,
    input  wire logic strobe_oe_n,
    // driven pins
    output logic      cs_n,
    output logic      sclk,
    output logic      din
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        din = 1'b0;
    end
    // mode 0 master, 50 percent duty; clock parks low between frames
    task automatic frame(input int lead, input logic [7:0] ctrl, input int nrise,
                         output logic [23:0] rx, output logic [23:0] st);
        logic [39:0] word;
        word = {ctrl, 32'h0} >> lead;
        rx = 24'h0;
        st = 24'h0;
        @(posedge core_clk) cs_n <= 1'b0;
        for (int i = 0; i < nrise; i++) begin
            @(posedge core_clk) begin
                sclk <= 1'b0;
                din <= word[39-i];
            end
            repeat (2) @(posedge core_clk);
            // released pins read as pulled high
            #1 rx = {rx[22:0], dout_oe_n | dout_o};
            st = {st[22:0], strobe_oe_n | strobe_o};
            @(posedge core_clk) sclk <= 1'b1;
            repeat (2) @(posedge core_clk);
        end
        @(posedge core_clk) sclk <= 1'b0;
        repeat (2) @(posedge core_clk);
        cs_n <= 1'b1;
        repeat (4) @(posedge core_clk);
    endtask
endmodule

//--- sim/sar_adc_serial_front_end_tb.sv
module sar_adc_serial_front_end_tb import adc_front_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk, rst_b, cs_n, sclk, din, dout_o, dout_oe_n, strobe_o, strobe_oe_n;
    logic shutdown_n, powered_down, comp_in, neg_is_com, tracking, hold_capacitor;
    logic [2:0] pos_sel, neg_sel;
    logic [11:0] dac_code, vin;
    logic [23:0] rx, st;
    logic [7:0] ctrl;
    logic [31:0] r;
    int seed = 92942;
    int lead;
    int failures = 0;
    int n_compared = 0;
    int trk_cycles = 0;
    logic hold_d = 1'b0;
    sar_adc_serial_front_end u_dut (.core_clk, .rst_b, .cs_n, .sclk, .din, .dout_o,
        .dout_oe_n, .strobe_o, .strobe_oe_n, .shutdown_n, .powered_down, .comp_in,
        .pos_sel, .neg_sel, .neg_is_com, .tracking, .hold_capacitor, .dac_code);
    host_master u_host (.core_clk, .dout_o, .dout_oe_n, .strobe_o, .strobe_oe_n,
        .cs_n, .sclk, .din);
    // ideal comparator: keep trial bit while trial code does not exceed the input
    assign comp_in = (dac_code <= vin);
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // host runs six core cycles per sclk period, so three periods of tracking
    always @(negedge core_clk) begin
        if (tracking) trk_cycles++;
        if (hold_capacitor && !hold_d) begin
            check(24'(trk_cycles), 24'h000012);
            trk_cycles = 0;
        end
        hold_d = hold_capacitor;
        if (hold_capacitor && ctrl[2]) begin
            check({21'h0, pos_sel}, {21'h0, ctrl[5], ctrl[4], ctrl[6]});
            check({23'h0, neg_is_com}, 24'h1);
        end else if (hold_capacitor) begin
            check({21'h0, pos_sel}, {21'h0, ctrl[5], ctrl[4], 1'b0});
            check({21'h0, neg_sel}, {21'h0, ctrl[5], ctrl[4], 1'b1});
            check({23'h0, neg_is_com}, 24'h0);
        end
    end
    initial begin
        repeat (60000) @(posedge core_clk);
        failures++;
        print_verdict;
    end
    initial begin
        rst_b = 1'b0;
        shutdown_n = 1'b1;
        vin = 12'h000;
        ctrl = 8'h80;
        repeat (12) @(posedge core_clk);
        rst_b <= 1'b1;
        for (int k = 0; k < 12; k++) begin
            r = $random(seed);
            vin <= r[11:0];
            ctrl = {1'b1, r[18:12]};
            lead = r[21:20] % 3;
            if (k == 3) u_host.frame(0, ctrl, 12, rx, st);
            u_host.frame(lead, ctrl, lead + 24, rx, st);
            check(rx, {11'h000, vin, 1'b0});
            check(st, 24'h002000);
        end
        shutdown_n <= 1'b0;
        u_host.frame(0, 8'hff, 24, rx, st);
        check({23'h0, powered_down}, 24'h1);
        check(rx | st, 24'h0);
        shutdown_n <= 1'b1;
        print_verdict;
    end
endmodule
